// [acsi_pkg.sv]
// Constants and carrier types for the analog channel status image block
// Functional notes
// - Eight 16-bit image words; config bit 15 picks data (1) or status (0).
// - Status bit 0 sets only after enable, configuration and one acquired sample.
// - Status bits 5:1 echo the configured input type code.
// - Status bits 7:6 echo the configured data format.
// - Status bits 9:8 echo the configured open-circuit response.
// - Voltage and 0-20 mA types need open-circuit disabled, else configuration error.
// - Status bits 11:10 echo the configured filter frequency.
// - Status bit 12 flags an open input or a shorted RTD input.
// - Open cold-junction sensor flags open circuit on thermocouple and CJC channels.
// - Cold-junction range error flags open circuit on thermocouple channels.
// - Status bit 13 flags input at or below the lower sensor limit.
// - Status bit 14 flags input at or above the upper sensor limit.
// - Status bit 15 flags invalid configuration or converter acquisition failure.
// - Auto-calibration tolerance failure also sets the channel error bit.
// - Data word keeps updating during calibration tolerance errors.
// - Error bits clear by themselves once the condition is gone.
// - A disabled channel reports an all-zero status word.
// - A disabled channel has its data word reset to zero.
package acsi_pkg;

	// ---------------------------------------------------------------
	// Sizes and register map
	// ---------------------------------------------------------------
	localparam int          NUM_CH       = 8;
	localparam int          ADDR_W       = 7;
	localparam logic [6:0]  OFS_CFG_BASE = 7'h00;
	localparam logic [6:0]  OFS_IMG_BASE = 7'h20;
	localparam logic [6:0]  OFS_IRQ_STAT = 7'h40;
	localparam logic [6:0]  OFS_IRQ_MASK = 7'h44;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;
	localparam logic [15:0] DATA_RST     = 16'h0000;

	// ---------------------------------------------------------------
	// Configuration and status word fields
	// ---------------------------------------------------------------
	localparam int CFG_EN_BIT   = 0;
	localparam int CFG_TYPE_LSB = 1;
	localparam int CFG_FMT_LSB  = 6;
	localparam int CFG_OC_LSB   = 8;
	localparam int CFG_FILT_LSB = 11;
	localparam int CFG_RTD_BIT  = 13;
	localparam int CFG_IMG_BIT  = 15;
	localparam int CFG_SEEN_W   = 14;
	localparam int ST_RUN_BIT   = 0;
	localparam int ST_TYPE_LSB  = 1;
	localparam int ST_FMT_LSB   = 6;
	localparam int ST_OC_LSB    = 8;
	localparam int ST_FILT_LSB  = 10;
	localparam int ST_ERR_LSB   = 12;
	localparam int ERR_OPEN     = 0;
	localparam int ERR_UNDER    = 1;
	localparam int ERR_OVER     = 2;
	localparam int ERR_CHAN     = 3;
	localparam int IRQ_ERR_LSB  = 0;
	localparam int IRQ_RDY_LSB  = 8;

	// ---------------------------------------------------------------
	// Input type codes and related constants
	// ---------------------------------------------------------------
	localparam logic [4:0] TYPE_NOOC_MA    = 5'h01;
	localparam logic [4:0] TYPE_NOOC_FIRST = 5'h05;
	localparam logic [4:0] TYPE_NOOC_LAST  = 5'h09;
	localparam logic [4:0] TYPE_TC_FIRST   = 5'h0a;
	localparam logic [4:0] TYPE_TC_LAST    = 5'h11;
	localparam logic [4:0] TYPE_INV_FIRST  = 5'h12;
	localparam logic [4:0] TYPE_INV_LAST   = 5'h1d;
	localparam logic [4:0] TYPE_TC_C       = 5'h1e;
	localparam logic [4:0] TYPE_CJC        = 5'h1f;
	localparam logic [1:0] OC_DISABLED     = 2'h3;
	localparam logic [2:0] RTD_FIRST_CH    = 3'h4;

	// ---------------------------------------------------------------
	// Synchroniser layout: four pin flags per channel, two CJC flags
	// ---------------------------------------------------------------
	localparam int FLAG_W       = 4;
	localparam int FL_OVER      = 0;
	localparam int FL_UNDER     = 1;
	localparam int FL_SHORT     = 2;
	localparam int FL_OPEN      = 3;
	localparam int SY_CJC_OPEN  = NUM_CH * FLAG_W;
	localparam int SY_CJC_RANGE = SY_CJC_OPEN + 1;
	localparam int SYNC_W       = SY_CJC_RANGE + 1;

	typedef enum logic [1:0] {
		CH_OFF    = 2'b00,
		CH_CONFIG = 2'b01,
		CH_RUN    = 2'b10
	} acsi_chan_e;

	typedef enum logic [2:0] {
		RG_CFG = 3'b000,
		RG_IMG = 3'b001,
		RG_IST = 3'b010,
		RG_IMK = 3'b011,
		RG_BAD = 3'b100
	} acsi_region_e;

	typedef struct packed {
		logic              awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic              wvalid;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [ADDR_W-1:0] araddr;
		logic              rready;
	} acsi_axi_req_s;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} acsi_axi_rsp_s;

	typedef struct packed {
		logic [15:0] sampleData;
		logic        sampleValid;
		logic        adcFault;
		logic        calTolErr;
		logic        openDet;
		logic        rtdShort;
		logic        underRange;
		logic        overRange;
	} acsi_fe_s;

	typedef struct packed {
		logic [NUM_CH-1:0][15:0] word;
		logic [15:0]             rdA;
		logic [15:0]             rdB;
	} acsi_mem_s;

	typedef struct packed {
		logic [SYNC_W-1:0]               syA;
		logic [SYNC_W-1:0]               syB;
		acsi_chan_e [NUM_CH-1:0]         chSt;
		logic [NUM_CH-1:0][CFG_SEEN_W-1:0] cfgSeen;
		logic [NUM_CH-1:0][15:0]         dataWord;
		logic [NUM_CH-1:0][15:0]         image;
		logic [NUM_CH-1:0][3:0]          errs;
		logic [NUM_CH-1:0]               chanEn;
		logic [NUM_CH-1:0]               cfgLoad;
		logic [2:0]                      scanIdx;
		logic [2:0]                      scanPrev;
		logic [15:0]                     ist;
		logic [15:0]                     imk;
		logic                            irq;
		logic                            awready;
		logic                            awHeld;
		logic [ADDR_W-1:0]               awAddr;
		logic                            wready;
		logic                            wHeld;
		logic [15:0]                     wData;
		logic [1:0]                      wStrb;
		logic                            bvalid;
		logic [1:0]                      bresp;
		logic                            arready;
		logic                            rdPh;
		logic [ADDR_W-1:0]               rdAddr;
		logic                            rvalid;
		logic [31:0]                     rdata;
		logic [1:0]                      rresp;
	} acsi_top_s;

endpackage

// [acsi_cfg_mem.sv]
// Channel configuration word store with two registered read ports
`timescale 1ns/100ps
module acsi_cfg_mem import acsi_pkg::*; (
	input  wire logic        clock,   // 200 MHz clock
	input  wire logic        resetn,  // Async reset, active low
	input  wire logic        wrEn,    // Write strobe
	input  wire logic [2:0]  wrAddr,  // Channel to write
	input  wire logic [15:0] wrData,  // Write data
	input  wire logic [1:0]  wrBe,    // Byte enables
	input  wire logic [2:0]  rdAddrA, // Scan read channel
	output logic      [15:0] rdDataA, // Scan read data
	input  wire logic [2:0]  rdAddrB, // Bus read channel
	output logic      [15:0] rdDataB  // Bus read data
);

	acsi_mem_s mem_ff;
	acsi_mem_s nxt_mem;

	// Byte-lane write; reads return the old word on a collision
	always_comb begin
		nxt_mem = mem_ff;
		for (int b = 0; b < 2; b++) begin
			if (wrEn && wrBe[b]) begin
				nxt_mem.word[wrAddr][b*8 +: 8] = wrData[b*8 +: 8];
			end
		end
		nxt_mem.rdA = mem_ff.word[rdAddrA];
		nxt_mem.rdB = mem_ff.word[rdAddrB];
	end

	// All channels come up disabled
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			mem_ff <= '0;
		end else begin
			mem_ff <= nxt_mem;
		end
	end

	assign rdDataA = mem_ff.rdA;
	assign rdDataB = mem_ff.rdB;

endmodule

// [acsi_top.sv]
// Eight-channel input image builder with AXI4-Lite register access
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module acsi_top import acsi_pkg::*; (
	input  wire logic                    clock,       // 200 MHz clock
	input  wire logic                    resetn,      // Async reset, active low
	input  wire acsi_axi_req_s           axiReq,      // AXI4-Lite master signals
	output acsi_axi_rsp_s                axiRsp,      // AXI4-Lite slave signals
	input  wire acsi_fe_s [NUM_CH-1:0]   feIn,        // Per-channel front end
	input  wire logic                    cjcOpen,     // Cold-junction sensor open
	input  wire logic                    cjcRangeErr, // Cold-junction out of range
	output logic [NUM_CH-1:0][15:0]      imageWord,   // Input image words
	output logic [NUM_CH-1:0]            chanEnable,  // Channel acquisition enable
	output logic [NUM_CH-1:0]            cfgLoad,     // Load new config pulse
	output logic                         irq          // Level interrupt
);

	acsi_top_s   st_ff;
	acsi_top_s   nxt_st;
	logic [15:0] memRdA;
	logic [15:0] memRdB;
	logic        memWe;

	// ---------------------------------------------------------------
	// Decode and classification helpers
	// ---------------------------------------------------------------

	// Word-aligned decode; low address bits are ignored
	function automatic acsi_region_e regionOf(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] w;
		w = {a[ADDR_W-1:2], 2'b00};
		if (w[6:5] == OFS_CFG_BASE[6:5]) begin
			regionOf = RG_CFG;
		end else if (w[6:5] == OFS_IMG_BASE[6:5]) begin
			regionOf = RG_IMG;
		end else if (w == OFS_IRQ_STAT) begin
			regionOf = RG_IST;
		end else if (w == OFS_IRQ_MASK) begin
			regionOf = RG_IMK;
		end else begin
			regionOf = RG_BAD;
		end
	endfunction

	// Lane-wise merge of the low two bytes
	function automatic logic [15:0] byteMerge(
		input logic [15:0] old,
		input logic [15:0] upd,
		input logic [1:0]  be
	);
		byteMerge = old;
		for (int b = 0; b < 2; b++) begin
			if (be[b]) begin
				byteMerge[b*8 +: 8] = upd[b*8 +: 8];
			end
		end
	endfunction

	function automatic logic isTc(input logic [4:0] t);
		isTc = (t >= TYPE_TC_FIRST && t <= TYPE_TC_LAST) || t == TYPE_TC_C;
	endfunction

	function automatic logic noOcType(input logic [4:0] t);
		noOcType = t == TYPE_NOOC_MA || (t >= TYPE_NOOC_FIRST && t <= TYPE_NOOC_LAST);
	endfunction

	// Bad type code, illegal open-circuit choice, or RTD on a low channel
	function automatic logic cfgInvalid(input logic [15:0] c, input logic [2:0] ch);
		logic [4:0] t;
		t = c[CFG_TYPE_LSB +: 5];
		cfgInvalid = 1'b0;
		if (t >= TYPE_INV_FIRST && t <= TYPE_INV_LAST) begin
			cfgInvalid = 1'b1;
		end
		if (noOcType(t) && c[CFG_OC_LSB +: 2] != OC_DISABLED) begin
			cfgInvalid = 1'b1;
		end
		if (c[CFG_RTD_BIT] && ch < RTD_FIRST_CH) begin
			cfgInvalid = 1'b1;
		end
	endfunction

	// Status word; all zero when the channel is disabled
	function automatic logic [15:0] statusWord(
		input logic [15:0] c,
		input logic        run,
		input logic [3:0]  err
	);
		statusWord = 16'h0000;
		if (c[CFG_EN_BIT]) begin
			statusWord[ST_RUN_BIT] = run;
			statusWord[ST_TYPE_LSB +: 5] = c[CFG_TYPE_LSB +: 5];
			statusWord[ST_FMT_LSB +: 2] = c[CFG_FMT_LSB +: 2];
			statusWord[ST_OC_LSB +: 2] = c[CFG_OC_LSB +: 2];
			statusWord[ST_FILT_LSB +: 2] = c[CFG_FILT_LSB +: 2];
			statusWord[ST_ERR_LSB +: 4] = err;
		end
	endfunction

	// ---------------------------------------------------------------
	// Configuration store
	// ---------------------------------------------------------------

	// Writes land one cycle after both halves of a write are held
	assign memWe = st_ff.awHeld && st_ff.wHeld && !st_ff.bvalid &&
		regionOf(st_ff.awAddr) == RG_CFG;

	acsi_cfg_mem u_cfg_mem (
		.clock   (clock),
		.resetn  (resetn),
		.wrEn    (memWe),
		.wrAddr  (st_ff.awAddr[4:2]),
		.wrData  (st_ff.wData),
		.wrBe    (st_ff.wStrb),
		.rdAddrA (st_ff.scanIdx),
		.rdDataA (memRdA),
		.rdAddrB (axiReq.araddr[4:2]),
		.rdDataB (memRdB)
	);

	// ---------------------------------------------------------------
	// Next-state logic
	// ---------------------------------------------------------------
	always_comb begin
		logic [15:0]       cfg;
		logic [2:0]        ch;
		logic [4:0]        typ;
		logic [3:0]        err;
		logic [NUM_CH-1:0] errSet;
		logic [NUM_CH-1:0] rdySet;
		logic [15:0]       istClr;
		logic              cjcOpenS;
		logic              cjcRangeS;
		acsi_region_e      rg;
		cfg       = memRdA;
		ch        = st_ff.scanPrev;
		typ       = memRdA[CFG_TYPE_LSB +: 5];
		err       = 4'h0;
		errSet    = '0;
		rdySet    = '0;
		istClr    = 16'h0000;
		cjcOpenS  = st_ff.syB[SY_CJC_OPEN];
		cjcRangeS = st_ff.syB[SY_CJC_RANGE];
		rg        = RG_BAD;
		nxt_st    = st_ff;

		// Pin flags pass two flops before use
		for (int c = 0; c < NUM_CH; c++) begin
			nxt_st.syA[c*FLAG_W +: FLAG_W] = {feIn[c].openDet, feIn[c].rtdShort,
				feIn[c].underRange, feIn[c].overRange};
		end
		nxt_st.syA[SY_CJC_OPEN]  = cjcOpen;
		nxt_st.syA[SY_CJC_RANGE] = cjcRangeErr;
		nxt_st.syB = st_ff.syA;

		// Sample capture runs regardless of error state
		for (int c = 0; c < NUM_CH; c++) begin
			if (feIn[c].sampleValid && st_ff.chSt[c] != CH_OFF) begin
				nxt_st.dataWord[c] = feIn[c].sampleData;
				if (st_ff.chSt[c] == CH_CONFIG) begin
					nxt_st.chSt[c] = CH_RUN;
					rdySet[c] = 1'b1;
				end
			end
		end

		// Round-robin scan; memory read lags the index by one cycle
		nxt_st.scanIdx  = st_ff.scanIdx + 3'h1;
		nxt_st.scanPrev = st_ff.scanIdx;
		nxt_st.cfgLoad  = '0;
		if (!cfg[CFG_EN_BIT]) begin
			nxt_st.chSt[ch]   = CH_OFF;
			nxt_st.errs[ch]   = 4'h0;
			nxt_st.chanEn[ch] = 1'b0;
			nxt_st.dataWord[ch] = DATA_RST;
		end else begin
			nxt_st.chanEn[ch] = 1'b1;
			if (st_ff.chSt[ch] == CH_OFF ||
				cfg[CFG_SEEN_W-1:0] != st_ff.cfgSeen[ch]) begin
				nxt_st.chSt[ch]    = CH_CONFIG;
				nxt_st.cfgLoad[ch] = 1'b1;
			end
			nxt_st.cfgSeen[ch] = cfg[CFG_SEEN_W-1:0];
			err[ERR_OPEN] = st_ff.syB[ch*FLAG_W + FL_OPEN] |
				st_ff.syB[ch*FLAG_W + FL_SHORT];
			if (cjcOpenS && (isTc(typ) || typ == TYPE_CJC)) begin
				err[ERR_OPEN] = 1'b1;
			end
			if (cjcRangeS && isTc(typ)) begin
				err[ERR_OPEN] = 1'b1;
			end
			err[ERR_UNDER] = st_ff.syB[ch*FLAG_W + FL_UNDER];
			err[ERR_OVER] = st_ff.syB[ch*FLAG_W + FL_OVER];
			err[ERR_CHAN] = cfgInvalid(cfg, ch) | feIn[ch].adcFault;
			if (feIn[ch].calTolErr) begin
				err[ERR_CHAN] = 1'b1;
			end
			nxt_st.errs[ch] = err;
			if (err != 4'h0 && st_ff.errs[ch] == 4'h0) begin
				errSet[ch] = 1'b1;
			end
		end
		// data or status per select bit
		if (cfg[CFG_IMG_BIT]) begin
			nxt_st.image[ch] = nxt_st.dataWord[ch];
		end else begin
			nxt_st.image[ch] = statusWord(cfg, nxt_st.chSt[ch] == CH_RUN,
				nxt_st.errs[ch]);
		end

		// Write channel: address and data taken in either order
		if (axiReq.awvalid && st_ff.awready) begin
			nxt_st.awHeld = 1'b1;
			nxt_st.awAddr = axiReq.awaddr;
		end
		if (axiReq.wvalid && st_ff.wready) begin
			nxt_st.wHeld = 1'b1;
			nxt_st.wData = axiReq.wdata[15:0];
			nxt_st.wStrb = axiReq.wstrb[1:0];
		end
		if (st_ff.bvalid && axiReq.bready) begin
			nxt_st.bvalid = 1'b0;
		end
		if (st_ff.awHeld && st_ff.wHeld && !st_ff.bvalid) begin
			nxt_st.awHeld = 1'b0;
			nxt_st.wHeld  = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp  = RESP_OKAY;
			rg = regionOf(st_ff.awAddr);
			if (rg == RG_IST) begin
				istClr = byteMerge(16'h0000, st_ff.wData, st_ff.wStrb);
			end else if (rg == RG_IMK) begin
				nxt_st.imk = byteMerge(st_ff.imk, st_ff.wData, st_ff.wStrb);
			end else if (rg != RG_CFG) begin
				// Image words are read-only; unmapped is an error too
				nxt_st.bresp = RESP_SLVERR;
			end
		end
		// No new write until the response has been taken
		nxt_st.awready = !nxt_st.awHeld && !nxt_st.bvalid;
		nxt_st.wready  = !nxt_st.wHeld && !nxt_st.bvalid;

		// Read channel: one cycle to fetch, then respond
		if (axiReq.arvalid && st_ff.arready) begin
			nxt_st.rdPh   = 1'b1;
			nxt_st.rdAddr = axiReq.araddr;
		end
		if (st_ff.rvalid && axiReq.rready) begin
			nxt_st.rvalid = 1'b0;
		end
		if (st_ff.rdPh) begin
			nxt_st.rdPh   = 1'b0;
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp  = RESP_OKAY;
			nxt_st.rdata  = 32'h0000_0000;
			rg = regionOf(st_ff.rdAddr);
			if (rg == RG_CFG) begin
				nxt_st.rdata[15:0] = memRdB;
			end else if (rg == RG_IMG) begin
				nxt_st.rdata[15:0] = st_ff.image[st_ff.rdAddr[4:2]];
			end else if (rg == RG_IST) begin
				nxt_st.rdata[15:0] = st_ff.ist;
			end else if (rg == RG_IMK) begin
				nxt_st.rdata[15:0] = st_ff.imk;
			end else begin
				nxt_st.rresp = RESP_SLVERR;
			end
		end
		nxt_st.arready = !nxt_st.rdPh && !nxt_st.rvalid;

		// Sticky events; a set in the clearing cycle wins
		nxt_st.ist = (st_ff.ist & ~istClr) |
			{rdySet, errSet} << IRQ_ERR_LSB;
		nxt_st.irq = |(nxt_st.ist & nxt_st.imk);
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------

	// Ready flags rise on the first edge after reset release
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ---------------------------------------------------------------
	// Outputs, all straight from the state register
	// ---------------------------------------------------------------
	assign axiRsp.awready = st_ff.awready;
	assign axiRsp.wready  = st_ff.wready;
	assign axiRsp.bvalid  = st_ff.bvalid;
	assign axiRsp.bresp   = st_ff.bresp;
	assign axiRsp.arready = st_ff.arready;
	assign axiRsp.rvalid  = st_ff.rvalid;
	assign axiRsp.rdata   = st_ff.rdata;
	assign axiRsp.rresp   = st_ff.rresp;
	assign imageWord      = st_ff.image;
	assign chanEnable     = st_ff.chanEn;
	assign cfgLoad        = st_ff.cfgLoad;
	assign irq            = st_ff.irq;

endmodule

// [acsi_top_props.sv]
// Checker for the channel status image block
`timescale 1ns/100ps
module acsi_top_props import acsi_pkg::*; (
	input wire logic                    clock,       // Clock
	input wire logic                    resetn,      // Reset, low
	input wire acsi_axi_req_s           axiReq,      // Bus in
	input wire acsi_axi_rsp_s           axiRsp,      // Bus out
	input wire acsi_fe_s [NUM_CH-1:0]   feIn,        // Front end
	input wire logic                    cjcOpen,     // CJC open
	input wire logic                    cjcRangeErr, // CJC range
	input wire logic [NUM_CH-1:0][15:0] imageWord,   // Images
	input wire logic [NUM_CH-1:0]       chanEnable,  // Enables
	input wire logic [NUM_CH-1:0]       cfgLoad,     // Loads
	input wire logic                    irq          // Interrupt
);
	// ----------------------------------------
	// Bus and image properties
	// ----------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	// Write answered two edges after both halves are taken
	property p_wr_ans;
		axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready |-> ##2 axiRsp.bvalid;
	endproperty
	a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
	// Taken response frees both write channels
	property p_b_done;
		axiRsp.bvalid && axiReq.bready |=> !axiRsp.bvalid && axiRsp.awready && axiRsp.wready;
	endproperty
	a_b_done: assert property (p_b_done) else $error("write response not retired");
	// Read answered two edges after address taken
	property p_ar_ans;
		axiReq.arvalid && axiRsp.arready |=> !axiRsp.arready ##1 axiRsp.rvalid;
	endproperty
	a_ar_ans: assert property (p_ar_ans) else $error("read answer late");
	// Read data held while the master stalls
	property p_r_hold;
		axiRsp.rvalid && !axiReq.rready |=> axiRsp.rvalid && $stable(axiRsp.rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	// Taken read data frees the read channel
	property p_r_done;
		axiRsp.rvalid && axiReq.rready |=> !axiRsp.rvalid && axiRsp.arready;
	endproperty
	a_r_done: assert property (p_r_done) else $error("read response not retired");
	// Load only on an enabled channel, one cycle
	property p_load;
		cfgLoad[1] |-> chanEnable[1] ##1 !cfgLoad[1];
	endproperty
	a_load: assert property (p_load) else $error("load pulse wrong");
	// Ready bit clear while configuring
	property p_load_st;
		cfgLoad[1] && !imageWord[1][15] |-> !imageWord[1][0];
	endproperty
	a_load_st: assert property (p_load_st) else $error("ready before sample");
	// Disabled channel shows an all-zero word
	property p_dis_zero;
		!chanEnable[1] |-> imageWord[1] == 16'h0000;
	endproperty
	a_dis_zero: assert property (p_dis_zero) else $error("disabled word not zero");
	c_load: cover property (cfgLoad[1]);
	c_open: cover property (imageWord[1][12]);
	c_irq: cover property (irq);
endmodule

bind acsi_top acsi_top_props i_acsi_top_props (
	.clock(clock), .resetn(resetn), .axiReq(axiReq), .axiRsp(axiRsp), .feIn(feIn),
	.cjcOpen(cjcOpen), .cjcRangeErr(cjcRangeErr), .imageWord(imageWord),
	.chanEnable(chanEnable), .cfgLoad(cfgLoad), .irq(irq)
);

// [acsi_fe_model.sv]
// Converter model answering each configuration load with samples
`timescale 1ns/100ps
module acsi_fe_model import acsi_pkg::*; #(
	parameter int DLY = 6 // Load to sample delay
) (
	input  wire logic                  clock,      // Clock
	input  wire logic                  resetn,     // Reset, low
	input  wire logic [NUM_CH-1:0]     cfgLoad,    // Load pulses
	input  wire logic [NUM_CH-1:0]     chanEnable, // Enables
	input  wire acsi_fe_s [NUM_CH-1:0] flagIn,     // Bench flags
	output acsi_fe_s [NUM_CH-1:0]      feOut       // To block
);
	int                cnt [NUM_CH];
	logic [14:0]       seq;
	logic [NUM_CH-1:0] sv;
	// Top bit set tells samples from status words
	always_comb begin
		feOut = flagIn;
		for (int n = 0; n < NUM_CH; n++) begin
			feOut[n].sampleValid = sv[n];
			feOut[n].sampleData = {1'b1, seq};
		end
	end
	// Reload on a load, then sample every 49 cycles
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			seq <= 15'h0000;
			sv <= '0;
			for (int n = 0; n < NUM_CH; n++) begin
				cnt[n] <= 0;
			end
		end else begin
			seq <= seq + 15'h0001;
			for (int n = 0; n < NUM_CH; n++) begin
				sv[n] <= (cnt[n] == 1);
				if (cfgLoad[n]) begin
					cnt[n] <= DLY;
				end else if (cnt[n] == 0 && chanEnable[n]) begin
					cnt[n] <= 48;
				end else if (cnt[n] > 0) begin
					cnt[n] <= cnt[n] - 1;
				end
			end
		end
	end
endmodule

// [acsi_top_tb_top.sv]
// Testbench for the channel status image block
`timescale 1ns/100ps
module acsi_top_tb_top import acsi_pkg::*; ;
	localparam logic [15:0] EFLAG [8] = '{16'h1000, 16'h1000, 16'h1000, 16'h1000,
		16'h2000, 16'h4000, 16'h8000, 16'h8000};
	localparam logic [6:0] CH1 = OFS_CFG_BASE + 7'h04;
	logic                    clock;
	logic                    resetn;
	acsi_axi_req_s           axiReq;
	acsi_axi_rsp_s           axiRsp;
	acsi_fe_s [NUM_CH-1:0]   feIn;
	acsi_fe_s [NUM_CH-1:0]   flg;
	logic                    cjcOpen;
	logic                    cjcRangeErr;
	logic [NUM_CH-1:0][15:0] imageWord;
	logic [NUM_CH-1:0]       chanEnable;
	logic [NUM_CH-1:0]       cfgLoad;
	logic                    irq;
	int                      miscompares;
	int                      cmp_count;
	int                      cyc = 0;

	acsi_top i_acsi_top (.clock(clock), .resetn(resetn), .axiReq(axiReq), .axiRsp(axiRsp),
		.feIn(feIn), .cjcOpen(cjcOpen), .cjcRangeErr(cjcRangeErr), .imageWord(imageWord),
		.chanEnable(chanEnable), .cfgLoad(cfgLoad), .irq(irq));
	acsi_fe_model i_acsi_fe_model (.clock(clock), .resetn(resetn), .cfgLoad(cfgLoad),
		.chanEnable(chanEnable), .flagIn(flg), .feOut(feIn));

	// ----------------------------------------
	// Clock, hang guard and helpers
	// ----------------------------------------
	initial clock = 1'b0;
	always #2.5 clock = ~clock;
	// Whole run needs under two thousand cycles
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			summarize();
		end
	end
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clock);
	endtask
	// Bus write: both halves offered together
	task automatic wr(input logic [6:0] a, input logic [15:0] d, input logic [1:0] rs);
		@(posedge clock);
		axiReq <= '{1'b1, a, 1'b1, {16'h0000, d}, 4'hf, 1'b1, 1'b0, 7'h00, 1'b0};
		do @(posedge clock); while (!(axiRsp.awready && axiRsp.wready));
		axiReq.awvalid <= 1'b0;
		axiReq.wvalid <= 1'b0;
		do @(posedge clock); while (!axiRsp.bvalid);
		axiReq.bready <= 1'b0;
		chk("bresp", {14'h0000, rs}, {14'h0000, axiRsp.bresp});
	endtask
	// Bus read: rready offered with the address
	task automatic rd(input logic [6:0] a, input logic [15:0] e, input logic [1:0] rs);
		@(posedge clock);
		axiReq <= '{1'b0, 7'h00, 1'b0, 32'h0, 4'h0, 1'b0, 1'b1, a, 1'b1};
		do @(posedge clock); while (!axiRsp.arready);
		axiReq.arvalid <= 1'b0;
		do @(posedge clock); while (!axiRsp.rvalid);
		axiReq.rready <= 1'b0;
		chk("rdata", e, axiRsp.rdata[15:0]);
		chk("rdata upper", 16'h0000, axiRsp.rdata[31:16]);
		chk("rresp", {14'h0000, rs}, {14'h0000, axiRsp.rresp});
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		rd(OFS_IRQ_MASK, 16'h0000, RESP_OKAY);
		wr(OFS_IMG_BASE, 16'h1234, RESP_SLVERR);
		rd(OFS_IMG_BASE, 16'h0000, RESP_OKAY);
		rd(7'h50, 16'h0000, RESP_SLVERR);
	endtask
	// Every type code; format, response, filter follow the low bits
	task automatic t_codes();
		logic [4:0]  ty;
		logic [1:0]  k;
		logic        e;
		logic [15:0] x;
		for (int t = 0; t < 32; t++) begin
			ty = 5'(t);
			k = ty[1:0];
			e = (ty >= TYPE_INV_FIRST && ty <= TYPE_INV_LAST) || (k != OC_DISABLED &&
				(ty == TYPE_NOOC_MA || (ty >= TYPE_NOOC_FIRST && ty <= TYPE_NOOC_LAST)));
			x = {e, 3'b000, k, k, k, ty, 1'b0};
			wr(CH1, {3'b000, k, 1'b0, k, k, ty, 1'b1}, RESP_OKAY);
			do @(posedge clock); while (!cfgLoad[1]);
			wt(1);
			chk("configuring", x, imageWord[1]);
			wt(20);
			chk("running", x | 16'h0001, imageWord[1]);
		end
	endtask
	// Each error source sets its bit and clears alone
	task automatic t_flags();
		logic [15:0] b;
		b = {10'h000, TYPE_TC_FIRST, 1'b1};
		wr(CH1, b, RESP_OKAY);
		wt(30);
		for (int i = 0; i < 8; i++) begin
			case (i)
				0: flg[1].openDet <= 1'b1;
				1: flg[1].rtdShort <= 1'b1;
				2: cjcOpen <= 1'b1;
				3: cjcRangeErr <= 1'b1;
				4: flg[1].underRange <= 1'b1;
				5: flg[1].overRange <= 1'b1;
				6: flg[1].adcFault <= 1'b1;
				default: flg[1].calTolErr <= 1'b1;
			endcase
			wt(14);
			chk("error set", b | EFLAG[i], imageWord[1]);
			flg <= '0;
			cjcOpen <= 1'b0;
			cjcRangeErr <= 1'b0;
			wt(14);
			chk("error cleared", b, imageWord[1]);
		end
	endtask
	// Data image under calibration error, then disable
	task automatic t_data();
		logic [15:0] a;
		flg[1].calTolErr <= 1'b1;
		wr(CH1, {1'b1, 9'h000, TYPE_TC_FIRST, 1'b1}, RESP_OKAY);
		wt(14);
		a = imageWord[1];
		chk("data shown", 16'h0001, {15'h0000, a !== 16'h8015});
		wt(60);
		chk("data moves", 16'h0001, {15'h0000, imageWord[1] !== a});
		chk("other image", 16'h0000, imageWord[0]);
		flg <= '0;
		wr(CH1, {10'h000, TYPE_TC_FIRST, 1'b1}, RESP_OKAY);
		wt(14);
		chk("status back", {10'h000, TYPE_TC_FIRST, 1'b1}, imageWord[1]);
		wr(CH1, 16'h8000, RESP_OKAY);
		wt(14);
		chk("data reset", 16'h0000, imageWord[1]);
		rd(OFS_IMG_BASE + 7'h04, 16'h0000, RESP_OKAY);
	endtask
	// Ready event: masked, unmasked, cleared
	task automatic t_irq();
		wr(OFS_IRQ_MASK, 16'h0000, RESP_OKAY);
		wr(OFS_IRQ_STAT, 16'hffff, RESP_OKAY);
		wr(CH1, {10'h000, TYPE_TC_FIRST, 1'b1}, RESP_OKAY);
		wt(30);
		chk("irq masked", 16'h0000, {15'h0000, irq});
		rd(OFS_IRQ_STAT, 16'h0200, RESP_OKAY);
		wr(OFS_IRQ_MASK, 16'h0200, RESP_OKAY);
		rd(OFS_IRQ_MASK, 16'h0200, RESP_OKAY);
		chk("irq raised", 16'h0001, {15'h0000, irq});
		wr(OFS_IRQ_STAT, 16'h0200, RESP_OKAY);
		wt(2);
		chk("irq cleared", 16'h0000, {15'h0000, irq});
		rd(OFS_IRQ_STAT, 16'h0000, RESP_OKAY);
	endtask

	// Main sequence
	initial begin
		axiReq = '0;
		flg = '0;
		cjcOpen = 1'b0;
		cjcRangeErr = 1'b0;
		resetn = 1'b0;
		miscompares = 0;
		cmp_count = 0;
		repeat (10) @(posedge clock);
		resetn <= 1'b1;
		t_reset();
		t_codes();
		t_flags();
		t_data();
		t_irq();
		summarize();
	end
endmodule
